//--- design/smcg_pkg.sv
// Package with the constants and carrier types of the sleep-mode clock gating block.
// Function
// - Halt opcode sleeps only with arm bit set
// - Mode 000 Idle stops core and nvm
// - Idle wakes on any enabled interrupt
// - Enabled converter starts conversion entering Idle/quiet
// - Comparator off bit removes comparator wake in Idle
// - Mode 001 quiet stops io, core, nvm
// - Quiet wakes on its listed sources only
// - Mode 010 Power-down stops all generated clocks
// - Power-down wakes on its listed sources only
// - Power-down wake waits fuse-selected stabilisation delay
// - Mode 011 Power-save keeps timer 2
// - Timer 2 wake needs mask and global enable
// - Power-save stops unused timer clock sources
// - Mode 110 Standby keeps oscillator, six cycles
// - Mode 111 Extended Standby, six cycle wake
// - Async clock and main source per mode
// - High group wakes only level-sensitive outside Idle
// - Three-bit field, codes 100 and 101 reserved
package smcg_pkg;

    localparam logic [2:0] MODE_IDLE = 3'h0;
    localparam logic [2:0] MODE_QUIET = 3'h1;
    localparam logic [2:0] MODE_PDOWN = 3'h2;
    localparam logic [2:0] MODE_PSAVE = 3'h3;
    localparam logic [2:0] MODE_RES4 = 3'h4;
    localparam logic [2:0] MODE_RES5 = 3'h5;
    localparam logic [2:0] MODE_STBY = 3'h6;
    localparam logic [2:0] MODE_XSTBY = 3'h7;

    // Standby wake time in clock cycles.
    localparam int STBY_WAKE_CYCLES = 6;
    // Counter width for all wake delays.
    localparam int WAKE_CNT_W = 16;
    // Default Power-down stabilisation time, one count per fuse step, in ns.
    localparam int PD_STEP_NS = 1000;
    localparam int CLK_PERIOD_NS = 5;
    localparam int PD_STEP_CYCLES = (PD_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Wake event bits gathered from the peripherals.
    typedef struct packed {
        logic ext_reset;
        logic dog_reset;
        logic dog_irq;
        logic brownout;
        logic addr_match;
        logic serial2_irq;
        logic t2_ovf;
        logic t2_cmp;
        logic nvm_ready;
        logic conv_done;
        logic comparator;
        logic pin_change;
        logic other_io;
        logic [3:0] ext_irq_low_group;
        logic [3:0] ext_irq_high_group;
    } smcg_wake_type;

    // Clock domain and oscillator enables.
    typedef struct packed {
        logic core_clock_domain;
        logic nvm_clock_domain;
        logic io_clock_domain;
        logic converter_clock_domain;
        logic async_timer_clock_domain;
        logic main_osc;
        logic timer_osc;
        logic t2_sync_clk;
    } smcg_clk_type;

    localparam smcg_clk_type CLK_ALL_ON = 8'hff;

endpackage

//--- design/smcg_wake_filter.sv
// Per-mode wake source qualification.
`timescale 1ns/100ps
module smcg_wake_filter (
    input wire logic [2:0] mode_i,
    input wire smcg_pkg::smcg_wake_type wake_i,
    input wire logic [3:0] high_group_level_i,
    input wire logic [1:0] t2_irq_mask_i,
    input wire logic global_irq_en_i,
    input wire logic comparator_off_bit_i,
    output logic wake_o
);

    logic resets;
    logic t2_any;
    logic high_lvl;
    logic low_any;
    logic w_idle;
    logic w_quiet;
    logic w_pdown;
    logic w_psave;

    // Resets and the dog timer interrupt wake every mode.
    assign resets = wake_i.ext_reset | wake_i.dog_reset | wake_i.brownout | wake_i.dog_irq;
    assign t2_any = ((wake_i.t2_ovf & t2_irq_mask_i[0]) | (wake_i.t2_cmp & t2_irq_mask_i[1]))
        & global_irq_en_i;
    // Outside Idle the high group counts only when level-sensitive.
    assign high_lvl = |(wake_i.ext_irq_high_group & high_group_level_i);
    assign low_any = |wake_i.ext_irq_low_group;

    // Idle takes everything, the comparator only while powered.
    assign w_idle = resets | wake_i.addr_match | wake_i.serial2_irq | wake_i.t2_ovf
        | wake_i.t2_cmp | wake_i.nvm_ready | wake_i.conv_done | wake_i.pin_change
        | wake_i.other_io | low_any | (|wake_i.ext_irq_high_group)
        | (wake_i.comparator & ~comparator_off_bit_i);
    assign w_quiet = resets | wake_i.conv_done | wake_i.serial2_irq | wake_i.addr_match
        | (wake_i.t2_ovf | wake_i.t2_cmp) | wake_i.nvm_ready | high_lvl | low_any
        | wake_i.pin_change;
    assign w_pdown = resets | wake_i.addr_match | high_lvl | low_any
        | wake_i.pin_change;
    // Save modes add the masked timer 2 events; a stopped timer raises none, so its clock
    // source does not need to be looked at here.
    assign w_psave = w_pdown | t2_any;

    always_comb
    begin
        case (mode_i)
            smcg_pkg::MODE_IDLE: wake_o = w_idle;
            smcg_pkg::MODE_QUIET: wake_o = w_quiet;
            smcg_pkg::MODE_PDOWN: wake_o = w_pdown;
            smcg_pkg::MODE_PSAVE: wake_o = w_psave;
            smcg_pkg::MODE_STBY: wake_o = w_pdown;
            smcg_pkg::MODE_XSTBY: wake_o = w_psave;
            default: wake_o = 1'b1;
        endcase
    end

endmodule

//--- design/smcg_top.sv
// Sleep-mode controller: enters sleep on the halt opcode, gates clocks, times wake-up.
`timescale 1ns/100ps
module smcg_top #(
    parameter int PD_STEP_CYCLES = smcg_pkg::PD_STEP_CYCLES
) (
    input wire logic sys_clk_i,
    input wire logic reset_i,
    input wire logic clk_en_i,
    input wire logic halt_op_i,
    input wire logic sleep_arm_bit_i,
    input wire logic [2:0] mode_select_field_i,
    input wire logic crystal_clock_i,
    input wire logic [3:0] osc_choice_fuses_i,
    input wire logic converter_en_i,
    input wire logic comparator_off_bit_i,
    input wire logic [1:0] t2_irq_mask_i,
    input wire logic global_irq_en_i,
    input wire logic t2_enabled_i,
    input wire logic t2_async_i,
    input wire logic [3:0] high_group_level_i,
    input wire smcg_pkg::smcg_wake_type wake_i,
    output smcg_pkg::smcg_clk_type clk_en_o,
    output logic core_stall_o,
    output logic conv_start_o,
    output logic comparator_pwr_o,
    output logic asleep_o,
    output logic [2:0] active_mode_o
);

    typedef enum {ST_RUN, ST_SLEEP, ST_WAKE} smcg_state_type;

    smcg_state_type state_reg;
    smcg_state_type state_next;
    logic [2:0] mode_reg;
    logic [smcg_pkg::WAKE_CNT_W-1:0] cnt_reg;
    logic [smcg_pkg::WAKE_CNT_W-1:0] cnt_next;
    smcg_pkg::smcg_clk_type clk_reg;
    smcg_pkg::smcg_clk_type gate_sleep;
    logic stall_reg;
    logic conv_reg;
    logic cmp_reg;
    logic wake;
    logic mode_ok;
    logic enter;
    logic [2:0] gate_mode;
    logic [smcg_pkg::WAKE_CNT_W-1:0] wake_delay;

    // A mode is legal when not reserved; standby pair needs a crystal source.
    function automatic logic smcg_mode_legal(input logic [2:0] m, input logic xtal);
        logic ok;
        ok = 1'b1;
        if (m == smcg_pkg::MODE_RES4 || m == smcg_pkg::MODE_RES5)
        begin
            ok = 1'b0;
        end
        else if (m == smcg_pkg::MODE_STBY || m == smcg_pkg::MODE_XSTBY)
        begin
            ok = xtal;
        end
        return ok;
    endfunction

    // Clock gating per mode.
    function automatic smcg_pkg::smcg_clk_type smcg_gate(input logic [2:0] m,
            input logic t2_on, input logic t2_as);
        smcg_pkg::smcg_clk_type g;
        g = '0;
        case (m)
            smcg_pkg::MODE_IDLE:
            begin
                g = smcg_pkg::CLK_ALL_ON;
                g.core_clock_domain = 1'b0;
                g.nvm_clock_domain = 1'b0;
                g.timer_osc = t2_as;
                g.t2_sync_clk = 1'b1;
            end
            smcg_pkg::MODE_QUIET:
            begin
                g.converter_clock_domain = 1'b1;
                g.async_timer_clock_domain = 1'b1;
                g.main_osc = 1'b1;
                g.timer_osc = t2_as;
                g.t2_sync_clk = 1'b0;
            end
            smcg_pkg::MODE_PDOWN:
            begin
                g = '0;
            end
            smcg_pkg::MODE_PSAVE:
            begin
                g.async_timer_clock_domain = 1'b1;
                g.timer_osc = t2_on & t2_as;
                g.t2_sync_clk = t2_on & ~t2_as;
            end
            smcg_pkg::MODE_STBY:
            begin
                g.main_osc = 1'b1;
            end
            smcg_pkg::MODE_XSTBY:
            begin
                g.main_osc = 1'b1;
                g.async_timer_clock_domain = t2_as;
                g.timer_osc = t2_on & t2_as;
                g.t2_sync_clk = t2_on & ~t2_as;
            end
            default:
            begin
                g = smcg_pkg::CLK_ALL_ON;
            end
        endcase
        return g;
    endfunction

    smcg_wake_filter u_filter (
        .mode_i(mode_reg),
        .wake_i(wake_i),
        .high_group_level_i(high_group_level_i),
        .t2_irq_mask_i(t2_irq_mask_i),
        .global_irq_en_i(global_irq_en_i),
        .comparator_off_bit_i(comparator_off_bit_i),
        .wake_o(wake)
    );

    // Entry decode: armed halt with a legal mode; otherwise the core keeps running.
    assign mode_ok = smcg_mode_legal(mode_select_field_i, crystal_clock_i);
    assign enter = halt_op_i & sleep_arm_bit_i & mode_ok;
    // The latched mode is still the old one at the entry edge, so gate on the field then.
    assign gate_mode = (state_reg == ST_RUN) ? mode_select_field_i : mode_reg;
    assign gate_sleep = smcg_gate(gate_mode, t2_enabled_i, t2_async_i);

    // Modes that stop the main source pay the fuse-selected restart time; the
    // fuse value scales one stabilisation step, so zero still gives one step.
    assign wake_delay = (mode_reg == smcg_pkg::MODE_STBY || mode_reg == smcg_pkg::MODE_XSTBY)
        ? smcg_pkg::WAKE_CNT_W'(smcg_pkg::STBY_WAKE_CYCLES)
        : (mode_reg == smcg_pkg::MODE_IDLE || mode_reg == smcg_pkg::MODE_QUIET)
        ? smcg_pkg::WAKE_CNT_W'(1)
        : smcg_pkg::WAKE_CNT_W'(PD_STEP_CYCLES * (osc_choice_fuses_i + 1));

    // Sequencer next state.
    always_comb
    begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        case (state_reg)
            ST_RUN:
            begin
                if (enter)
                begin
                    state_next = ST_SLEEP;
                end
            end
            ST_SLEEP:
            begin
                if (wake)
                begin
                    state_next = ST_WAKE;
                    cnt_next = wake_delay - smcg_pkg::WAKE_CNT_W'(1);
                end
            end
            ST_WAKE:
            begin
                if (cnt_reg == '0)
                begin
                    state_next = ST_RUN;
                end
                else
                begin
                    cnt_next = cnt_reg - smcg_pkg::WAKE_CNT_W'(1);
                end
            end
            default:
            begin
                state_next = ST_RUN;
            end
        endcase
    end

    // State and mode capture; the mode is latched at entry so later writes do no harm.
    always_ff @(posedge sys_clk_i)
    begin
        if (reset_i)
        begin
            state_reg <= ST_RUN;
            mode_reg <= smcg_pkg::MODE_IDLE;
            cnt_reg <= '0;
        end
        else if (clk_en_i)
        begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            if (state_reg == ST_RUN && enter)
            begin
                mode_reg <= mode_select_field_i;
            end
        end
    end

    // Registered outputs; clocks stay gated through the wake delay until stable.
    always_ff @(posedge sys_clk_i)
    begin
        if (reset_i)
        begin
            clk_reg <= smcg_pkg::CLK_ALL_ON;
            stall_reg <= 1'b0;
            conv_reg <= 1'b0;
            cmp_reg <= 1'b1;
        end
        else if (clk_en_i)
        begin
            clk_reg <= (state_next == ST_RUN) ? smcg_pkg::CLK_ALL_ON : gate_sleep;
            stall_reg <= (state_next != ST_RUN);
            conv_reg <= (state_reg == ST_RUN) & enter & converter_en_i
                & (mode_select_field_i == smcg_pkg::MODE_IDLE
                | mode_select_field_i == smcg_pkg::MODE_QUIET);
            cmp_reg <= ~comparator_off_bit_i;
        end
    end

    assign clk_en_o = clk_reg;
    assign core_stall_o = stall_reg;
    assign conv_start_o = conv_reg;
    assign comparator_pwr_o = cmp_reg;
    assign asleep_o = stall_reg;
    assign active_mode_o = mode_reg;

endmodule

//--- test/smcg_properties.sv
// Concurrent checks on the ports of the sleep-mode clock gating block.
`timescale 1ns/100ps
module smcg_properties (
    input wire logic sys_clk_i,
    input wire logic reset_i,
    input wire logic clk_en_i,
    input wire logic halt_op_i,
    input wire logic sleep_arm_bit_i,
    input wire logic [2:0] mode_select_field_i,
    input wire smcg_pkg::smcg_wake_type wake_i,
    input wire smcg_pkg::smcg_clk_type clk_en_o,
    input wire logic conv_start_o,
    input wire logic asleep_o,
    input wire logic [2:0] active_mode_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (reset_i);

    // Entry needs an armed halt; reserved codes must never stop anything.
    a_halt_unarmed: assert property (clk_en_i && halt_op_i && !sleep_arm_bit_i && !asleep_o
        |=> !asleep_o) else $error("unarmed halt entered sleep");
    a_entry_cause: assert property ($rose(asleep_o) |-> $past(halt_op_i)
        && $past(sleep_arm_bit_i)) else $error("sleep entered without armed halt");
    a_reserved_halt: assert property (!asleep_o && halt_op_i
        && mode_select_field_i[2:1] == 2'b10 |=> !asleep_o) else $error("reserved code slept");
    // Gating for Idle, quiet, Power-down and Standby holds for the whole time the core is stalled.
    a_idle_gating: assert property (asleep_o && active_mode_o == 3'h0 |-> clk_en_o[7:5]
        == 3'b001) else $error("idle gating wrong");
    a_quiet_gating: assert property (asleep_o && active_mode_o == 3'h1
        |-> clk_en_o[7:2] == 6'b000111) else $error("quiet gating wrong");
    a_pdown_gating: assert property (asleep_o && active_mode_o == 3'h2
        |-> clk_en_o == 8'h00) else $error("power-down clock left running");
    a_stby_osc: assert property (asleep_o && active_mode_o == 3'h6
        |-> clk_en_o[7:2] == 6'b000001) else $error("standby oscillator wrong");
    // Standby variants are fast: six cycles plus registering.
    a_stby_wake: assert property (clk_en_i && asleep_o && active_mode_o[2:1] == 2'b11
        && (wake_i.addr_match || wake_i.pin_change) |-> ##[1:8] !asleep_o)
        else $error("standby wake too slow");
    a_conv_entry: assert property (conv_start_o |-> asleep_o
        && active_mode_o[2:1] == 2'b00) else $error("conversion start outside idle or quiet");
endmodule

//--- test/smcg_core_model.sv
// Behavioural core and peripheral partner: issues halts and holds wake levels.
`timescale 1ns/100ps
module smcg_core_model (
    input wire logic clk_i,
    input wire logic go_i,
    input wire logic arm_i,
    input wire logic stall_i,
    input wire smcg_pkg::smcg_wake_type wake_req_i,
    output logic halt_o,
    output logic arm_o,
    output smcg_pkg::smcg_wake_type wake_o
);
    // Arm rises with the halt and drops once the core runs again, so no stray sleep.
    // Wake levels are held until the core resumes, since a short level may be missed.
    always @(negedge clk_i)
    begin
        halt_o <= go_i;
        arm_o <= (go_i & arm_i) | (arm_o & (stall_i | halt_o));
        wake_o <= smcg_pkg::smcg_wake_type'(wake_req_i | (wake_o & {21{stall_i}}));
    end
endmodule

//--- test/smcg_top_tb.sv
// Self-checking testbench of the sleep-mode clock gating block.
`timescale 1ns/100ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin errors++; \
    $display("ERROR %0t: got %h expected %h", $time, g, e); end end
module smcg_top_tb;
    localparam int PD = 2;
    logic clk, rst, ce, go, arm, crystal, comp_off, glob, halt, armo;
    logic [2:0] mode;
    logic [3:0] fuses;
    logic [20:0] wreq;
    smcg_pkg::smcg_wake_type wake;
    smcg_pkg::smcg_clk_type clko;
    logic stall, conv, cpwr, asleep, conv_seen;
    logic [2:0] amode;
    int errors = 0;
    int num_checks = 0;
    logic [2:0] t_mode [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h6, 3'h7};
    logic [7:0] t_clk [6] = '{8'h3f, 8'h1e, 8'h00, 8'h0a, 8'h04, 8'h0e};
    logic [7:0] t_mask [6] = '{8'hff, 8'hfe, 8'hff, 8'hff, 8'hff, 8'hff};
    logic [3:0] t_fuse [6] = '{4'h0, 4'h0, 4'h0, 4'hf, 4'h0, 4'h0};
    logic [20:0] t_wake [6] = '{21'h000100, 21'h000800, 21'h000010, 21'h004002,
        21'h000001, 21'h010000};

    smcg_core_model core (.clk_i(clk), .go_i(go), .arm_i(arm), .stall_i(stall),
        .wake_req_i(smcg_pkg::smcg_wake_type'(wreq)), .halt_o(halt), .arm_o(armo), .wake_o(wake));

    // Timer 2 runs asynchronously with overflow enabled, so Power-save is apt.
    // The converter stays on; only high group pin 0 is level-sensitive.
    smcg_top #(.PD_STEP_CYCLES(PD)) uut (.sys_clk_i(clk), .reset_i(rst), .clk_en_i(ce),
        .halt_op_i(halt), .sleep_arm_bit_i(armo), .mode_select_field_i(mode),
        .crystal_clock_i(crystal), .osc_choice_fuses_i(fuses), .converter_en_i(1'b1),
        .comparator_off_bit_i(comp_off), .t2_irq_mask_i(2'h1), .global_irq_en_i(glob),
        .t2_enabled_i(1'b1), .t2_async_i(1'b1), .high_group_level_i(4'h1), .wake_i(wake),
        .clk_en_o(clko), .core_stall_o(stall), .conv_start_o(conv), .comparator_pwr_o(cpwr),
        .asleep_o(asleep), .active_mode_o(amode));

    // Clock at 200 MHz.
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic report_and_stop();
        $display("Checks %0d, mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // Halt through the core model; returns once the answer has settled.
    task automatic halt_req(input logic [2:0] m, input logic a);
        mode <= m;
        arm <= a;
        go <= 1'b1;
        @(negedge clk);
        go <= 1'b0;
        @(negedge clk);
        // The conversion start pulse stands only in the cycle after the entry edge.
        conv_seen = conv;
        @(negedge clk);
    endtask

    // Counts edges after the one that took the wake until the core resumes.
    task automatic wake_count(input int exp_n);
        int n;
        n = 0;
        while (asleep === 1'b1 && n < 100)
        begin
            @(posedge clk);
            n++;
            @(negedge clk);
        end
        if (n >= 100)
        begin
            errors++;
            report_and_stop();
        end
        else
        begin
            `CHK(n, exp_n)
        end
    endtask

    initial
    begin
        int d;
        rst = 1'b1; ce = 1'b1; go = 1'b0; arm = 1'b0; mode = 3'h0; crystal = 1'b0;
        comp_off = 1'b1; glob = 1'b1; fuses = 4'h0; wreq = '0;
        repeat (20) @(negedge clk);
        rst <= 1'b0;
        @(negedge clk);
        // Halts that must be refused leave every clock running.
        halt_req(3'h0, 1'b0);
        `CHK(asleep, 1'b0)
        `CHK(cpwr, 1'b0)
        `CHK(conv_seen, 1'b0)
        ce <= 1'b0;
        halt_req(3'h0, 1'b1);
        ce <= 1'b1;
        `CHK(asleep, 1'b0)
        for (int i = 4; i < 6; i++)
        begin
            halt_req(3'(i), 1'b1);
            `CHK(clko, 8'hff)
        end
        halt_req(3'h6, 1'b1);
        `CHK(asleep, 1'b0)
        $display("Test refusals done");
        crystal <= 1'b1;
        comp_off <= 1'b0;
        // Every legal mode: gating, wake source and wake time.
        for (int i = 0; i < 6; i++)
        begin
            fuses <= t_fuse[i];
            glob <= (t_mode[i] != smcg_pkg::MODE_PSAVE);
            halt_req(t_mode[i], 1'b1);
            `CHK(clko & t_mask[i], t_clk[i])
            `CHK(stall, 1'b1)
            `CHK(conv_seen, t_mode[i][2:1] == 2'b00)
            wreq <= t_wake[i];
            @(negedge clk);
            wreq <= '0;
            @(negedge clk);
            if (t_mode[i] == smcg_pkg::MODE_PSAVE)
            begin
                repeat (20) @(negedge clk);
                `CHK(asleep, 1'b1)
                glob <= 1'b1;
                // Let the edge that sees the wake pass, as in the other modes.
                @(negedge clk);
            end
            d = t_mode[i][2] ? smcg_pkg::STBY_WAKE_CYCLES : 1;
            if (t_mode[i][2:1] == 2'b01)
                d = PD * (int'(t_fuse[i]) + 1);
            wake_count(d);
            `CHK(clko, 8'hff)
            `CHK(amode, t_mode[i])
            $display("Test mode %0d done", t_mode[i]);
        end
        report_and_stop();
    end
endmodule

bind smcg_top smcg_properties u_props (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
    .clk_en_i(clk_en_i), .halt_op_i(halt_op_i), .sleep_arm_bit_i(sleep_arm_bit_i),
    .mode_select_field_i(mode_select_field_i), .wake_i(wake_i), .clk_en_o(clk_en_o),
    .conv_start_o(conv_start_o), .asleep_o(asleep_o), .active_mode_o(active_mode_o));
